/* src/ptd_data_path.sv */
// phy data path: mac-facing clocks, transmit timing, receive carrier and data
`timescale 1ns/1ps
module ptd_data_path
    import ptd_pkg::*;
#(
    parameter int RX_LAT = int'(RX_LAT_CYC)
)(
    input  wire logic    ref_clk,
    input  wire logic    rst_n,
    input  wire logic    line_clk,
    input  wire logic    speed_100,
    input  wire logic    serial_mode,
    input  wire ptd_tx_s mac_tx,
    input  wire logic    lr_j,
    input  wire logic    lr_t,
    input  wire ptd_rx_s lr_rx,
    input  wire logic    lr_locked,
    output ptd_tx_s      line_tx,
    output logic         line_tx_hi,
    output logic         line_sos,
    output logic         line_eos,
    output logic         mii_tx_clk,
    output logic         mii_rx_clk,
    output ptd_rx_s      mii_rx,
    output logic         mii_crs
);

    // a line change launched at edge n is first seen by a check at edge n+1
    localparam int J_DLY    = int'(TX_J_CYC) + 1;
    localparam int T_DLY    = int'(TX_T_CYC) + 1;
    localparam int T10_DLY  = int'(TX10_CYC) + 1;
    localparam int CON_100  = int'(CRS_ON_100);
    localparam int COFF_100 = int'(CRS_OFF_100);
    localparam int RX_DLY   = RX_LAT;

    //------------------------------------------------------------
    // line clock domain: event toggles and word handshake
    //------------------------------------------------------------
    logic [1:0] lrst_q;
    logic [1:0] ak_sy_q;
    logic       j_tg_q, j_tg_d;
    logic       t_tg_q, t_tg_d;
    logic       rq_tg_q, rq_tg_d;
    ptd_rx_s    lw_q, lw_d;
    logic       lbusy;
    logic       ak_tg_q, ak_tg_d;

    always_comb begin
        lbusy   = rq_tg_q != ak_sy_q[1];
        j_tg_d  = j_tg_q ^ lr_j;
        t_tg_d  = t_tg_q ^ lr_t;
        rq_tg_d = rq_tg_q;
        lw_d    = lw_q;
        // a word offered while the previous one is unacknowledged is dropped
        if (lr_rx.dv && !lbusy) begin
            lw_d    = lr_rx;
            rq_tg_d = !rq_tg_q;
        end
    end

    always_ff @(posedge line_clk) begin
        lrst_q  <= {lrst_q[0], rst_n};
        ak_sy_q <= {ak_sy_q[0], ak_tg_q};
        if (!lrst_q[1]) begin
            j_tg_q  <= 1'b0;
            t_tg_q  <= 1'b0;
            rq_tg_q <= 1'b0;
            lw_q    <= '0;
        end else begin
            j_tg_q  <= j_tg_d;
            t_tg_q  <= t_tg_d;
            rq_tg_q <= rq_tg_d;
            lw_q    <= lw_d;
        end
    end

    //------------------------------------------------------------
    // synchronisers into the reference domain
    //------------------------------------------------------------
    ptd_tx_s    tx_m_q, tx_s_q;
    logic [2:0] j_sy_q, t_sy_q, rq_sy_q;
    logic [1:0] lk_sy_q;
    logic       j_ev, t_ev, rq_ev;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_m_q  <= '0;
            tx_s_q  <= '0;
            j_sy_q  <= '0;
            t_sy_q  <= '0;
            rq_sy_q <= '0;
            lk_sy_q <= '0;
        end else begin
            tx_m_q  <= mac_tx;
            tx_s_q  <= tx_m_q;
            j_sy_q  <= {j_sy_q[1:0], j_tg_q};
            t_sy_q  <= {t_sy_q[1:0], t_tg_q};
            rq_sy_q <= {rq_sy_q[1:0], rq_tg_q};
            lk_sy_q <= {lk_sy_q[0], lr_locked};
        end
    end

    assign j_ev  = j_sy_q[1] ^ j_sy_q[2];
    assign t_ev  = t_sy_q[1] ^ t_sy_q[2];
    assign rq_ev = rq_sy_q[1] ^ rq_sy_q[2];

    //------------------------------------------------------------
    // transmit clock and sampling edge
    //------------------------------------------------------------
    logic     tck_q, tck_d;
    ptd_cnt_t tcnt_q, tcnt_d;
    ptd_cnt_t thi, tlo;
    logic     nib10, samp_ev;

    always_comb begin
        thi    = serial_mode ? TXS_HI : (speed_100 ? TXH_100 : TXH_10);
        tlo    = serial_mode ? TXS_LO : (speed_100 ? TXH_100 : TXH_10);
        tcnt_d = tcnt_q - CNT_ONE;
        tck_d  = tck_q;
        if (tcnt_q <= CNT_ONE) begin
            tck_d  = !tck_q;
            tcnt_d = tck_q ? tlo : thi;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tck_q  <= 1'b0;
            tcnt_q <= CNT_ONE;
        end else begin
            tck_q  <= tck_d;
            tcnt_q <= tcnt_d;
        end
    end

    // in 10M nibble mode the mac launches on the rising edge, so the falling edge is mid-window
    assign nib10   = !speed_100 && !serial_mode;
    assign samp_ev = nib10 ? (tck_q && !tck_d) : (!tck_q && tck_d);

    //------------------------------------------------------------
    // transmit framing to the line
    //------------------------------------------------------------
    ptd_tx_e  st_q, st_d;
    ptd_cnt_t tc_q, tc_d;
    ptd_tx_s  ltx_q, ltx_d;
    logic     hi_q, hi_d;
    logic     sos_q, sos_d;
    logic     eos_q, eos_d;
    logic     ep_q, ep_d;
    ptd_cnt_t ec_q, ec_d;

    always_comb begin
        st_d  = st_q;
        tc_d  = tc_q;
        ep_d  = ep_q;
        ec_d  = ec_q;
        if (ec_q != '0) begin
            ec_d = ec_q - CNT_ONE;
        end
        ltx_d = ltx_q;
        hi_d  = hi_q;
        sos_d = 1'b0;
        eos_d = 1'b0;
        if (tc_q != '0) begin
            tc_d = tc_q - CNT_ONE;
        end
        case (st_q)
            TX_IDLE: begin
                if (samp_ev && tx_s_q.en) begin
                    st_d    = TX_WAIT_SOS;
                    ltx_d.d = tx_s_q.d;
                    tc_d    = speed_100 ? TX_J_CYC : TX10_CYC;
                    ep_d    = 1'b0;
                end
            end
            TX_WAIT_SOS: begin
                if (samp_ev && tx_s_q.en) begin
                    ltx_d.d = tx_s_q.d;
                end else if (samp_ev && !ep_q) begin
                    // end seen before the start left: time it from its own edge
                    ep_d = 1'b1;
                    ec_d = speed_100 ? TX_T_CYC : TX10_CYC;
                end
                if (tc_q == CNT_ONE) begin
                    ltx_d.en = 1'b1;
                    sos_d    = 1'b1;
                    st_d     = TX_ACTIVE;
                    if (ep_q) begin
                        st_d = TX_WAIT_EOS;
                        tc_d = ec_q - CNT_ONE;
                    end else if (samp_ev && !tx_s_q.en) begin
                        st_d = TX_WAIT_EOS;
                        tc_d = speed_100 ? TX_T_CYC : TX10_CYC;
                    end
                end
            end
            TX_ACTIVE: begin
                if (samp_ev) begin
                    if (tx_s_q.en) begin
                        ltx_d.d = tx_s_q.d;
                    end else begin
                        st_d = TX_WAIT_EOS;
                        tc_d = speed_100 ? TX_T_CYC : TX10_CYC;
                    end
                end
            end
            TX_WAIT_EOS: begin
                if (tc_q == CNT_ONE) begin
                    ltx_d.en = 1'b0;
                    eos_d    = 1'b1;
                    st_d     = TX_IDLE;
                    if (!speed_100) begin
                        hi_d = 1'b1;
                        tc_d = EOP_TYP_CYC;
                        st_d = TX_EOP_HOLD;
                    end
                end
            end
            TX_EOP_HOLD: begin
                if (tc_q == CNT_ONE) begin
                    hi_d = 1'b0;
                    st_d = TX_IDLE;
                end
            end
            default: begin
                st_d = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q  <= TX_IDLE;
            tc_q  <= '0;
            ltx_q <= '0;
            hi_q  <= 1'b0;
            sos_q <= 1'b0;
            eos_q <= 1'b0;
            ep_q  <= 1'b0;
            ec_q  <= '0;
        end else begin
            ep_q  <= ep_d;
            ec_q  <= ec_d;
            st_q  <= st_d;
            tc_q  <= tc_d;
            ltx_q <= ltx_d;
            hi_q  <= hi_d;
            sos_q <= sos_d;
            eos_q <= eos_d;
        end
    end

    //------------------------------------------------------------
    // carrier sense
    //------------------------------------------------------------
    logic     cr_q, cr_d;
    logic     cp_q, cp_d;
    ptd_cnt_t cc_q, cc_d;

    always_comb begin
        cr_d = cr_q;
        cp_d = cp_q;
        cc_d = cc_q;
        if (cc_q != '0) begin
            cc_d = cc_q - CNT_ONE;
            if (cc_q == CNT_ONE) begin
                cr_d = cp_q;
            end
        end
        if (j_ev) begin
            cp_d = 1'b1;
            cc_d = (speed_100 ? CRS_ON_100 : CRS_ON_10) - CNT_ONE;
        end else if (t_ev) begin
            cp_d = 1'b0;
            cc_d = (speed_100 ? CRS_OFF_100 : CRS_OFF_10) - CNT_ONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cr_q <= 1'b0;
            cp_q <= 1'b0;
            cc_q <= '0;
        end else begin
            cr_q <= cr_d;
            cp_q <= cp_d;
            cc_q <= cc_d;
        end
    end

    //------------------------------------------------------------
    // receive latency pipeline
    //------------------------------------------------------------
    ptd_rx_s rp_q [RX_LAT];

    generate
        for (genvar i = 0; i < RX_LAT; i++) begin : g_rxp
            ptd_rx_s stg_d;
            if (i == 0) begin : g_head
                assign stg_d = '{dv: rq_ev, d: lw_q.d};
            end else begin : g_body
                assign stg_d = rp_q[i-1];
            end
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    rp_q[i] <= '0;
                end else begin
                    rp_q[i] <= stg_d;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ak_tg_q <= 1'b0;
        end else begin
            ak_tg_q <= ak_tg_d;
        end
    end

    assign ak_tg_d = ak_tg_q ^ rq_ev;

    //------------------------------------------------------------
    // receive clock with source switchover
    //------------------------------------------------------------
    logic     rck_q, rck_d;
    logic     rsrc_q, rsrc_d;
    ptd_cnt_t rcnt_q, rcnt_d;
    ptd_cnt_t rlen_q, rlen_d;
    ptd_cnt_t rph_q, rph_d;
    ptd_cnt_t rhalf;

    always_comb begin
        rhalf  = serial_mode ? RXH_SER : (speed_100 ? RXH_100 : RXH_10);
        rcnt_d = rcnt_q - CNT_ONE;
        rck_d  = rck_q;
        rsrc_d = rsrc_q;
        rlen_d = rlen_q;
        if (rcnt_q <= CNT_ONE) begin
            rcnt_d = rhalf;
            rlen_d = rhalf;
            if (rsrc_q != lk_sy_q[1]) begin
                rsrc_d = lk_sy_q[1];
            end else begin
                rck_d = !rck_q;
            end
        end
        rph_d = (rck_d != rck_q) ? CNT_ONE : rph_q + ((rph_q == '1) ? '0 : CNT_ONE);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rck_q  <= 1'b0;
            rsrc_q <= 1'b0;
            rcnt_q <= CNT_ONE;
            rlen_q <= CNT_ONE;
            rph_q  <= CNT_ONE;
        end else begin
            rck_q  <= rck_d;
            rsrc_q <= rsrc_d;
            rcnt_q <= rcnt_d;
            rlen_q <= rlen_d;
            rph_q  <= rph_d;
        end
    end

    //------------------------------------------------------------
    // receive output launch
    //------------------------------------------------------------
    ptd_rx_s hd_q, hd_d;
    ptd_rx_s mx_q, mx_d;
    logic    rl_ev;

    always_comb begin
        rl_ev = serial_mode ? (rck_q && !rck_d) : (!rck_q && rck_d);
        hd_d  = hd_q;
        mx_d  = mx_q;
        if (rl_ev) begin
            mx_d    = hd_q;
            mx_d.dv = hd_q.dv || (mx_q.dv && cr_q);
            hd_d.dv = 1'b0;
        end
        if (rp_q[RX_LAT-1].dv) begin
            hd_d = rp_q[RX_LAT-1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hd_q <= '0;
            mx_q <= '0;
        end else begin
            hd_q <= hd_d;
            mx_q <= mx_d;
        end
    end

    assign line_tx    = ltx_q;
    assign line_tx_hi = hi_q;
    assign line_sos   = sos_q;
    assign line_eos   = eos_q;
    assign mii_tx_clk = tck_q;
    assign mii_rx_clk = rck_q;
    assign mii_rx     = mx_q;
    assign mii_crs    = cr_q;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ptd_cnt_t hl_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n || !hi_q) begin
            hl_q <= '0;
        end else if (hl_q != '1) begin
            hl_q <= hl_q + CNT_ONE;
        end
    end

    sequence sos_go;
        st_q == TX_IDLE && samp_ev && tx_s_q.en;
    endsequence

    sequence eos_go;
        st_q == TX_ACTIVE && samp_ev && !tx_s_q.en;
    endsequence

    tx_sos_delay_a: assert property (sos_go ##0 speed_100 |-> ##J_DLY $rose(line_tx.en) ##0 line_sos)
        else $error("J start not at its latency");
    tx_eos_delay_a: assert property (eos_go ##0 speed_100 |-> ##T_DLY $fell(line_tx.en) ##0 line_eos)
        else $error("T start not at its latency");
    crs_on_a: assert property (j_ev && speed_100 && !cr_q ##1 !t_ev [*2] |-> ##(CON_100 - 2) $rose(mii_crs))
        else $error("carrier on late or early");
    rx_latency_a: assert property (rq_ev |-> ##RX_DLY rp_q[RX_LAT-1].dv)
        else $error("receive word latency wrong");
    crs_off_a: assert property (t_ev && speed_100 && cr_q ##1 !j_ev [*2] |-> ##(COFF_100 - 2) $fell(mii_crs))
        else $error("carrier off late or early");
    nib_sample_a: assert property (samp_ev && nib10 |=> $fell(mii_tx_clk))
        else $error("nibble sample not at falling edge");
    ser_sample_a: assert property (samp_ev && serial_mode |=> $rose(mii_tx_clk))
        else $error("serial sample not at rising edge");
    tx10_start_a: assert property (sos_go ##0 !speed_100 |-> ##T10_DLY $rose(line_tx.en))
        else $error("10M line output latency wrong");
    eop_high_a: assert property ($fell(line_tx.en) && !speed_100 |-> line_tx_hi [*2])
        else $error("line not held high at end");
    eop_len_a: assert property ($fell(line_tx_hi) |-> $past(hl_q) >= EOP_MIN_CYC)
        else $error("end high time too short");
    rx_phase_min_a: assert property ((rck_d != rck_q) |-> rph_q >= rlen_q && rph_q >= RXH_100)
        else $error("receive clock phase too short");
    rx_launch_a: assert property (serial_mode && $changed(mii_rx) |-> $fell(mii_rx_clk))
        else $error("serial receive data not on falling edge");

endmodule

/* src/ptd_pkg.sv */
// constants and types for the phy to mac data path timing block
package ptd_pkg;

    //------------------------------------------------------------
    // time base
    //------------------------------------------------------------
    localparam int CLK_NS     = 25;
    localparam int BIT_NS_100 = 10;
    localparam int BIT_NS_10  = 100;
    localparam int CNT_W      = 8;
    localparam int DATA_W     = 4;

    typedef logic [CNT_W-1:0] ptd_cnt_t;

    localparam ptd_cnt_t CNT_ONE = 8'h01;

    // least times round up to whole cycles, never below one
    function automatic ptd_cnt_t ptd_cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        if (c < 1) begin
            c = 1;
        end
        return ptd_cnt_t'(c);
    endfunction

    //------------------------------------------------------------
    // latencies in bit times and in ns
    //------------------------------------------------------------
    localparam int J_BITS       = 6;
    localparam int T_BITS       = 6;
    localparam int CRS_ON_BITS  = 20;
    localparam int CRS_OFF_BITS = 24;
    localparam int RX_LAT_BITS  = 24;
    localparam int TX10_TENTHS  = 35;
    localparam int EOP_MIN_NS   = 250;
    localparam int EOP_TYP_NS   = 300;

    localparam ptd_cnt_t TX_J_CYC    = ptd_cyc_up(J_BITS * BIT_NS_100);
    localparam ptd_cnt_t TX_T_CYC    = ptd_cyc_up(T_BITS * BIT_NS_100);
    localparam ptd_cnt_t TX10_CYC    = ptd_cyc_up(TX10_TENTHS * BIT_NS_10 / 10);
    localparam ptd_cnt_t CRS_ON_100  = ptd_cyc_up(CRS_ON_BITS * BIT_NS_100);
    localparam ptd_cnt_t CRS_OFF_100 = ptd_cyc_up(CRS_OFF_BITS * BIT_NS_100);
    localparam ptd_cnt_t CRS_ON_10   = ptd_cyc_up(CRS_ON_BITS * BIT_NS_10);
    localparam ptd_cnt_t CRS_OFF_10  = ptd_cyc_up(CRS_OFF_BITS * BIT_NS_10);
    localparam ptd_cnt_t RX_LAT_CYC  = ptd_cyc_up(RX_LAT_BITS * BIT_NS_100);
    localparam ptd_cnt_t EOP_MIN_CYC = ptd_cyc_up(EOP_MIN_NS);
    localparam ptd_cnt_t EOP_TYP_CYC = ptd_cyc_up(EOP_TYP_NS);

    //------------------------------------------------------------
    // interface clock half periods
    //------------------------------------------------------------
    localparam ptd_cnt_t TXH_100 = ptd_cyc_up(20);
    localparam ptd_cnt_t TXH_10  = ptd_cyc_up(200);
    localparam ptd_cnt_t TXS_HI  = ptd_cyc_up(25);
    localparam ptd_cnt_t TXS_LO  = ptd_cyc_up(75);
    localparam ptd_cnt_t RXH_100 = ptd_cyc_up(20);
    localparam ptd_cnt_t RXH_10  = ptd_cyc_up(200);
    localparam ptd_cnt_t RXH_SER = ptd_cyc_up(50);

    //------------------------------------------------------------
    // types
    //------------------------------------------------------------
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_WAIT_SOS,
        TX_ACTIVE,
        TX_WAIT_EOS,
        TX_EOP_HOLD
    } ptd_tx_e;

    typedef struct packed {
        logic              en;
        logic [DATA_W-1:0] d;
    } ptd_tx_s;

    typedef struct packed {
        logic              dv;
        logic [DATA_W-1:0] d;
    } ptd_rx_s;

endpackage

/* verif/ptd_mac_model.sv */
// mac partner model: drives transmit frames and notes the device's sampling edges
`timescale 1ns/1ps
module ptd_mac_model
    import ptd_pkg::*;
(
    input  wire logic mii_tx_clk,
    input  wire logic speed_100,
    input  wire logic serial_mode,
    output ptd_tx_s   mac_tx
);
    realtime t_on;
    realtime t_off;
    bit      want_on;
    bit      want_off;

    initial begin
        mac_tx   = '0;
        want_on  = 1'b0;
        want_off = 1'b0;
    end

    // sampling edge is falling in 10M nibble mode, rising otherwise
    always @(mii_tx_clk) begin
        if (mii_tx_clk === (speed_100 | serial_mode)) begin
            t_on     = want_on ? $realtime : t_on;
            t_off    = want_off ? $realtime : t_off;
            want_on  = 1'b0;
            want_off = 1'b0;
        end
    end

    // serial data at 10M moves on the falling edge so the rising sample never races it
    task automatic launch_edge();
        if (serial_mode && !speed_100) begin
            @(negedge mii_tx_clk);
        end else begin
            @(posedge mii_tx_clk);
        end
        #1;
    endtask

    task automatic send(input logic [DATA_W-1:0] nib[$]);
        launch_edge();
        want_on = 1'b1;
        foreach (nib[i]) begin
            mac_tx.en = 1'b1;
            mac_tx.d  = nib[i];
            launch_edge();
        end
        // data lines are inverted once after the frame so stale data is never reused
        mac_tx   = '{en: 1'b0, d: ~mac_tx.d};
        want_off = 1'b1;
    endtask
endmodule

/* verif/test_phy_mac_data_path_timing.sv */
// self-checking bench for the phy data path timing block
`timescale 1ns/1ps
module test_phy_mac_data_path_timing
    import ptd_pkg::*;
;
    logic    ref_clk, rst_n, line_clk, speed_100, serial_mode;
    logic    lr_j, lr_t, lr_locked, line_tx_hi, line_sos, line_eos;
    logic    mii_tx_clk, mii_rx_clk, mii_crs;
    ptd_tx_s mac_tx, line_tx;
    ptd_rx_s lr_rx, mii_rx;
    int      error_cnt, num_checks, seed;
    bit      chk_clk;
    realtime t_edge, t_rise, t_fall;

    ptd_data_path i_ptd_data_path (
        .ref_clk, .rst_n, .line_clk, .speed_100, .serial_mode, .mac_tx,
        .lr_j, .lr_t, .lr_rx, .lr_locked, .line_tx, .line_tx_hi, .line_sos,
        .line_eos, .mii_tx_clk, .mii_rx_clk, .mii_rx, .mii_crs
    );

    ptd_mac_model i_ptd_mac_model (.mii_tx_clk, .speed_100, .serial_mode, .mac_tx);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        line_clk = 1'b0;
        #1.7;
        forever #3 line_clk = ~line_clk;
    end

    task automatic chk(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic int cyc(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    function automatic bit in_win(input realtime d, input int lo, input int slack);
        return d >= lo * CLK_NS && d <= (lo + slack) * CLK_NS;
    endfunction

    function automatic int bit_ns();
        return speed_100 ? 10 : 100;
    endfunction

    // receive clock phases measured against the least high or low time
    always @(mii_rx_clk) begin
        if (chk_clk) begin
            chk($realtime - t_edge >= (speed_100 ? 16 : serial_mode ? 35 : 160), "rx clock phase short");
        end
        t_edge = $realtime;
        t_rise = mii_rx_clk ? $realtime : t_rise;
        t_fall = mii_rx_clk ? t_fall : $realtime;
    end

    task automatic set_mode(input int m);
        chk_clk = 1'b0;
        @(posedge ref_clk);
        #1;
        rst_n       = 1'b0;
        speed_100   = (m == 0);
        serial_mode = (m == 2);
        repeat (3) @(posedge ref_clk);
        #1;
        chk({line_tx, line_tx_hi, line_sos, line_eos, mii_rx, mii_crs} === '0, "outputs not clear in reset");
        rst_n = 1'b1;
        repeat (2) @(posedge mii_rx_clk);
        chk_clk = 1'b1;
    endtask

    task automatic tx_frame(input int len);
        logic [DATA_W-1:0] q[$];
        int                lat;
        int                hold;
        for (int i = 0; i < len; i++) begin
            q.push_back(serial_mode ? DATA_W'($random(seed) & 1) : DATA_W'($random(seed)));
        end
        lat = speed_100 ? cyc(6 * bit_ns()) : cyc(35 * bit_ns() / 10);
        fork
            i_ptd_mac_model.send(q);
            begin
                @(posedge line_sos);
                chk(in_win($realtime - i_ptd_mac_model.t_on, lat, 2), "start delay");
                #2;
                chk(line_tx.en === 1'b1, "line output not active");
                @(posedge line_eos);
                chk(in_win($realtime - i_ptd_mac_model.t_off, lat, 2), "end delay");
                #2;
                chk(line_tx.en === 1'b0 && line_tx.d === q[len - 1], "last nibble");
                hold = 0;
                while (line_tx_hi === 1'b1 && hold < 40) begin
                    @(posedge ref_clk);
                    #2;
                    hold++;
                end
                chk(hold == (speed_100 ? 0 : cyc(300)), "end high hold");
            end
        join
    endtask

    task automatic crs_edge(input logic on);
        realtime t0;
        int      n;
        @(posedge line_clk);
        #1;
        lr_j = on;
        lr_t = !on;
        t0   = $realtime;
        @(posedge line_clk);
        #1;
        lr_j = 1'b0;
        lr_t = 1'b0;
        n    = 0;
        do begin
            @(posedge ref_clk);
            #2;
            n++;
        end while (mii_crs !== on && n < 200);
        chk(in_win($realtime - 2 - t0, cyc((on ? 20 : 24) * bit_ns()), 5), "carrier delay");
    endtask

    task automatic rx_word();
        realtime           t0;
        int                n;
        logic [DATA_W-1:0] d;
        d = serial_mode ? DATA_W'(~mii_rx.d[0]) : mii_rx.d ^ DATA_W'(($random(seed) & 7) + 1);
        @(posedge line_clk);
        #1;
        lr_locked = 1'($random(seed));
        lr_rx     = '{dv: 1'b1, d: d};
        t0        = $realtime;
        @(posedge line_clk);
        #1;
        lr_rx = '{dv: 1'b0, d: ~d};
        n     = 0;
        do begin
            @(posedge ref_clk);
            #2;
            n++;
        end while (!(mii_rx.dv === 1'b1 && mii_rx.d === d) && n < 80);
        chk(mii_rx.dv === 1'b1 && mii_rx.d === d, "rx word lost");
        chk(in_win($realtime - 2 - t0, cyc(24 * 10), 36), "rx latency");
        chk((serial_mode ? t_fall : t_rise) == $realtime - 2, "rx launch edge");
    endtask

    initial begin
        seed        = 32'h2d5e;
        error_cnt   = 0;
        num_checks  = 0;
        chk_clk     = 1'b0;
        rst_n       = 1'b0;
        speed_100   = 1'b1;
        serial_mode = 1'b0;
        lr_j        = 1'b0;
        lr_t        = 1'b0;
        lr_locked   = 1'b0;
        lr_rx       = '0;
        for (int m = 0; m < 3; m++) begin
            set_mode(m);
            tx_frame(2 + ($random(seed) & 3));
            tx_frame(1);
            crs_edge(1'b1);
            repeat (3) rx_word();
            crs_edge(1'b0);
        end
        print_verdict();
    end

    initial begin
        #500_000;
        chk(1'b0, "timeout");
        print_verdict();
    end
endmodule
